/* File: inc/port_mux_pkg.sv */
// ----------------------------------------------------------------
// shared constants of the pin configuration and mux block
// ----------------------------------------------------------------
package port_mux_pkg;

	// structure of one port group
	localparam int PIN_COUNT = 32;
	localparam int PAIR_COUNT = 16;
	localparam int FUNC_COUNT = 8;
	localparam int GROUP_SPAN = 32'h80;
	localparam int ADDR_W = $clog2(GROUP_SPAN);

	// register offsets inside the group
	localparam logic [6:0] MULTI_CFG_OFS = 7'h28;
	localparam logic [6:0] FUNC_SEL_OFS = 7'h30;
	localparam logic [6:0] PIN_CFG_OFS = 7'h40;

	// multi-pin configuration write fields
	localparam int HALF_SEL_BIT = 31;
	localparam int CFG_UPDATE_BIT = 30;
	localparam int FUNC_UPDATE_BIT = 28;
	localparam int FUNC_FIELD_LSB = 24;
	localparam int MC_DRIVE_BIT = 22;
	localparam int MC_PULL_BIT = 18;
	localparam int MC_INBUF_BIT = 17;
	localparam int MC_MUXEN_BIT = 16;
	localparam int MASK_W = 16;

	// pin configuration byte fields
	localparam int CFG_DRIVE_BIT = 6;
	localparam int CFG_PULL_BIT = 2;
	localparam int CFG_INBUF_BIT = 1;
	localparam int CFG_MUXEN_BIT = 0;

	// function select byte fields and encoding
	localparam int FUNC_W = 4;
	localparam int ODD_FUNC_LSB = 4;
	localparam int EVEN_FUNC_LSB = 0;
	localparam logic [3:0] FUNC_LAST = 4'h7;

	// reset values
	localparam logic PIN_CFG_RESET = 1'b0;
	localparam logic [3:0] FUNC_SEL_RESET = 4'h0;

endpackage

/* File: hw/input_sync.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// two-flop synchroniser for the asynchronous pad levels
// ----------------------------------------------------------------
module input_sync
	import port_mux_pkg::*;
#(
	parameter int W = PIN_COUNT
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_reg; // first stage, read by the second only

	// both stages clear on reset; nothing else looks at meta_reg
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

/* File: hw/pad_function_mux.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// one pin: chooses port or peripheral control and gates the input
// ----------------------------------------------------------------
module pad_function_mux
	import port_mux_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pin configuration
	input wire logic drive_strength,
	input wire logic pull_enable,
	input wire logic input_buffer_enable,
	input wire logic peripheral_mux_enable,
	input wire logic [FUNC_W-1:0] pin_function,
	// port registers and peripherals
	input wire logic port_dir,
	input wire logic port_out,
	input wire logic [FUNC_COUNT-1:0] func_oe,
	input wire logic [FUNC_COUNT-1:0] func_out,
	input wire logic pin_sync,
	// pad and input value
	output logic pad_out,
	output logic pad_oe,
	output logic pad_drive_strong,
	output logic pad_pull_en,
	output logic pad_in_en,
	output logic pin_level
);

	logic func_ok; // encoding names a real function
	logic oe_next;
	logic out_next;

	// reserved codes select nothing, so the pad is released
	always_comb
	begin
		func_ok = pin_function <= FUNC_LAST; // [R10]
		oe_next = port_dir;
		out_next = port_out;
		if (peripheral_mux_enable) // [R15]
		begin
			oe_next = func_ok & func_oe[pin_function[2:0]];
			out_next = func_ok & func_out[pin_function[2:0]];
		end
	end

	// pad controls, registered so every output leaves a flop
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
			pad_drive_strong <= 1'b0;
			pad_pull_en <= 1'b0;
			pad_in_en <= 1'b0;
		end
		else
		begin
			pad_out <= out_next; // [R15]
			pad_oe <= oe_next;
			pad_drive_strong <= drive_strength; // [R12]
			pad_pull_en <= pull_enable; // [R13]
			pad_in_en <= input_buffer_enable;
		end
	end

	// input level reads zero while the buffer is off, even under mux
	always_ff @(posedge mclk)
	begin
		if (rst)
			pin_level <= 1'b0;
		else
			pin_level <= input_buffer_enable & pin_sync; // [R14] [R16]
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_port_owns_pad: assert property (!peripheral_mux_enable |=> // [R15]
		pad_oe == $past(port_dir) && pad_out == $past(port_out))
		else $error("port registers did not drive the pad");
	a_input_gated_off: assert property (!input_buffer_enable |=> // [R14]
		!pin_level)
		else $error("pin level seen with input buffer off");
	a_reserved_releases: assert property ( // [R10]
		peripheral_mux_enable && pin_function > FUNC_LAST |=> !pad_oe)
		else $error("reserved function code drove the pad");

endmodule

/* File: hw/port_pin_config_and_mux.sv */
// Strobed register access was decided locally.
`timescale 1ns/10ps
// Overview of operation
// R1 - multi write copies bit 22 to drive
// R2 - multi write copies bit 18 to pull
// R3 - multi write copies bit 17 to input enable
// R4 - multi write copies bit 16 to mux enable
// R5 - low sixteen bits mask pins in half-word
// R6 - multi-pin register always reads as zero
// R7 - sixteen pair select bytes from offset 0x30
// R8 - high nibble picks odd pin function
// R9 - low nibble picks even pin function
// R10 - codes 0 to 7 are A to H
// R11 - thirty-two pin config bytes, reset zero
// R12 - bit 6 selects strong output drive
// R13 - bit 2 enables the pull resistor
// R14 - bit 1 clear blanks the pin input
// R15 - bit 0 hands pad to peripheral
// R16 - level still readable under mux if enabled
// R17 - reserved bits ignore writes, read zero
module port_pin_config_and_mux
	import port_mux_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// port direction and output value registers
	input wire logic [PIN_COUNT-1:0] port_dir,
	input wire logic [PIN_COUNT-1:0] port_out,
	// peripheral functions, entry pin*8+function
	input wire logic [PIN_COUNT*FUNC_COUNT-1:0] func_oe,
	input wire logic [PIN_COUNT*FUNC_COUNT-1:0] func_out,
	// pads
	input wire logic [PIN_COUNT-1:0] pad_in,
	output logic [PIN_COUNT-1:0] pad_out,
	output logic [PIN_COUNT-1:0] pad_oe,
	output logic [PIN_COUNT-1:0] pad_drive_strong,
	output logic [PIN_COUNT-1:0] pad_pull_en,
	output logic [PIN_COUNT-1:0] pad_in_en,
	// sampled pin levels for the input register and peripherals
	output logic [PIN_COUNT-1:0] pin_level
);

	// ----------------------------------------------------------------
	// configuration state
	// ----------------------------------------------------------------

	logic [PIN_COUNT-1:0] drive_strength_reg; // strong drive per pin
	logic [PIN_COUNT-1:0] pull_enable_reg; // pull resistor per pin
	logic [PIN_COUNT-1:0] input_buffer_enable_reg; // input buffer per pin
	logic [PIN_COUNT-1:0] peripheral_mux_enable_reg; // mux owns the pad
	logic [FUNC_W-1:0] pin_function_reg [PIN_COUNT]; // function per pin
	logic [PIN_COUNT-1:0] pin_sync; // pad levels after two flops

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------

	logic [6:0] pair_ofs; // distance from the first pair select byte
	logic [6:0] pin_ofs; // distance from the first pin config byte
	logic hit_multi; // multi-pin configuration word
	logic hit_pair; // one of the pair select bytes
	logic hit_pin; // one of the pin config bytes
	logic [3:0] pair_idx;
	logic [4:0] pin_idx;

	// map of one group: multi word at 0x28, pair selects at 0x30..0x3f,
	// pin config bytes at 0x40..0x5f; every other offset is a hole
	// that ignores writes and reads zero. only one group is built, so
	// the group stride never shows inside this block.
	// subtraction wraps for low addresses, the range test catches it
	always_comb
	begin
		pair_ofs = reg_addr - FUNC_SEL_OFS;
		pin_ofs = reg_addr - PIN_CFG_OFS;
		hit_multi = reg_addr == MULTI_CFG_OFS;
		hit_pair = reg_addr >= FUNC_SEL_OFS && // [R7]
			pair_ofs < 7'(PAIR_COUNT);
		hit_pin = reg_addr >= PIN_CFG_OFS && // [R11]
			pin_ofs < 7'(PIN_COUNT);
		pair_idx = pair_ofs[3:0];
		pin_idx = pin_ofs[4:0];
	end

	// ----------------------------------------------------------------
	// multi-pin write
	// ----------------------------------------------------------------

	logic [PIN_COUNT-1:0] sel_mask; // pins chosen by the multi write
	logic mc_cfg_wr; // multi write that updates pin config
	logic mc_func_wr; // multi write that updates functions
	logic [MASK_W-1:0] pin_select_mask;
	logic half_word_select;

	// one multi write may change both config and function of up to
	// sixteen pins in the same cycle; with neither update flag set it
	// leaves everything alone
	// the mask lands on the lower or upper sixteen pins
	always_comb
	begin
		pin_select_mask = reg_wdata[MASK_W-1:0];
		half_word_select = reg_wdata[HALF_SEL_BIT];
		if (half_word_select) // [R5]
			sel_mask = {pin_select_mask, {MASK_W{1'b0}}};
		else
			sel_mask = {{MASK_W{1'b0}}, pin_select_mask};
		mc_cfg_wr = reg_wr && hit_multi && reg_wdata[CFG_UPDATE_BIT];
		mc_func_wr = reg_wr && hit_multi && reg_wdata[FUNC_UPDATE_BIT];
	end

	// ----------------------------------------------------------------
	// per-pin storage and pad logic
	// ----------------------------------------------------------------

	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++)
		begin : g_pin
			// config bits: multi write and byte write use different
			// addresses, so they can never collide in one cycle
			always_ff @(posedge mclk)
			begin
				if (rst) // [R11]
				begin
					drive_strength_reg[p] <= PIN_CFG_RESET;
					pull_enable_reg[p] <= PIN_CFG_RESET;
					input_buffer_enable_reg[p] <= PIN_CFG_RESET;
					peripheral_mux_enable_reg[p] <= PIN_CFG_RESET;
				end
				else if (mc_cfg_wr && sel_mask[p]) // [R5]
				begin
					drive_strength_reg[p] <= reg_wdata[MC_DRIVE_BIT]; // [R1]
					pull_enable_reg[p] <= reg_wdata[MC_PULL_BIT]; // [R2]
					input_buffer_enable_reg[p] <=
						reg_wdata[MC_INBUF_BIT]; // [R3]
					peripheral_mux_enable_reg[p] <=
						reg_wdata[MC_MUXEN_BIT]; // [R4]
				end
				else if (reg_wr && hit_pin && pin_idx == 5'(p))
				begin
					// reserved bits of the byte are simply not stored
					drive_strength_reg[p] <= reg_wdata[CFG_DRIVE_BIT]; // [R17]
					pull_enable_reg[p] <= reg_wdata[CFG_PULL_BIT];
					input_buffer_enable_reg[p] <= reg_wdata[CFG_INBUF_BIT];
					peripheral_mux_enable_reg[p] <= reg_wdata[CFG_MUXEN_BIT];
				end
			end

			// function nibble: odd pins use the high half of the pair byte
			always_ff @(posedge mclk)
			begin
				if (rst)
					pin_function_reg[p] <= FUNC_SEL_RESET;
				else if (mc_func_wr && sel_mask[p])
					pin_function_reg[p] <=
						reg_wdata[FUNC_FIELD_LSB +: FUNC_W];
				else if (reg_wr && hit_pair && pair_idx == 4'(p / 2))
				begin
					if (p % 2 == 1) // [R8]
						pin_function_reg[p] <= reg_wdata[ODD_FUNC_LSB +: FUNC_W];
					else // [R9]
						pin_function_reg[p] <= reg_wdata[EVEN_FUNC_LSB +: FUNC_W];
				end
			end

			// the function field of a multi write lands on chosen pins
			a_multi_func_copy: assert property (@(posedge mclk) // [R5]
				disable iff (rst)
				mc_func_wr && sel_mask[p] |=>
				pin_function_reg[p] ==
				$past(reg_wdata[FUNC_FIELD_LSB +: FUNC_W]))
				else $error("multi write did not copy the function");

			// config moves only when a write names this pin
			a_cfg_held_idle: assert property (@(posedge mclk) // [R5]
				disable iff (rst)
				!(mc_cfg_wr && sel_mask[p]) &&
				!(reg_wr && hit_pin && pin_idx == 5'(p)) |=>
				$stable({drive_strength_reg[p], pull_enable_reg[p],
				input_buffer_enable_reg[p],
				peripheral_mux_enable_reg[p]}))
				else $error("pin config changed without a write");

			// pad control and input gating for this pin
			pad_function_mux u_pad
			(
				.mclk(mclk),
				.rst(rst),
				.drive_strength(drive_strength_reg[p]),
				.pull_enable(pull_enable_reg[p]),
				.input_buffer_enable(input_buffer_enable_reg[p]),
				.peripheral_mux_enable(peripheral_mux_enable_reg[p]),
				.pin_function(pin_function_reg[p]),
				.port_dir(port_dir[p]),
				.port_out(port_out[p]),
				.func_oe(func_oe[p*FUNC_COUNT +: FUNC_COUNT]),
				.func_out(func_out[p*FUNC_COUNT +: FUNC_COUNT]),
				.pin_sync(pin_sync[p]),
				.pad_out(pad_out[p]),
				.pad_oe(pad_oe[p]),
				.pad_drive_strong(pad_drive_strong[p]),
				.pad_pull_en(pad_pull_en[p]),
				.pad_in_en(pad_in_en[p]),
				.pin_level(pin_level[p])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// pad level synchroniser
	// ----------------------------------------------------------------

	// pads are asynchronous to mclk; two flops before any gate
	input_sync #(.W(PIN_COUNT)) u_sync
	(
		.mclk(mclk),
		.rst(rst),
		.async_in(pad_in),
		.sync_out(pin_sync)
	);

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------

	logic [31:0] rdata_next;

	// the read mux is combinational on the live registers, so a read
	// right behind a write already returns the new value; that costs
	// a wide mux but keeps the bus free of wait states
	// the multi-pin word and unmapped offsets read zero
	always_comb
	begin
		rdata_next = '0;
		if (hit_pin) // [R17]
		begin
			rdata_next[CFG_DRIVE_BIT] = drive_strength_reg[pin_idx];
			rdata_next[CFG_PULL_BIT] = pull_enable_reg[pin_idx];
			rdata_next[CFG_INBUF_BIT] = input_buffer_enable_reg[pin_idx];
			rdata_next[CFG_MUXEN_BIT] = peripheral_mux_enable_reg[pin_idx];
		end
		else if (hit_pair)
		begin
			rdata_next[ODD_FUNC_LSB +: FUNC_W] =
				pin_function_reg[{pair_idx, 1'b1}];
			rdata_next[EVEN_FUNC_LSB +: FUNC_W] =
				pin_function_reg[{pair_idx, 1'b0}];
		end
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge mclk)
	begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rdata_next; // [R6]
		else
			reg_rdata <= '0;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_pin_byte_write;
		reg_wr && hit_pin && !reg_rd;
	endsequence

	sequence s_pin_byte_read;
		reg_rd && hit_pin && pin_idx == $past(pin_idx) && !reg_wr;
	endsequence

	a_multi_drive_copy: assert property (mc_cfg_wr |=> // [R1]
		(drive_strength_reg & $past(sel_mask)) ==
		({PIN_COUNT{$past(reg_wdata[MC_DRIVE_BIT])}} & $past(sel_mask)))
		else $error("multi write did not copy drive strength");
	a_multi_pull_copy: assert property (mc_cfg_wr |=> // [R2]
		(pull_enable_reg & $past(sel_mask)) ==
		({PIN_COUNT{$past(reg_wdata[MC_PULL_BIT])}} & $past(sel_mask)))
		else $error("multi write did not copy pull enable");
	a_multi_inbuf_copy: assert property (mc_cfg_wr |=> // [R3]
		(input_buffer_enable_reg & $past(sel_mask)) ==
		({PIN_COUNT{$past(reg_wdata[MC_INBUF_BIT])}} & $past(sel_mask)))
		else $error("multi write did not copy input enable");
	a_multi_muxen_copy: assert property (mc_cfg_wr |=> // [R4]
		(peripheral_mux_enable_reg & $past(sel_mask)) ==
		({PIN_COUNT{$past(reg_wdata[MC_MUXEN_BIT])}} & $past(sel_mask)))
		else $error("multi write did not copy mux enable");
	a_mask_keeps_pins: assert property (mc_cfg_wr |=> // [R5]
		(peripheral_mux_enable_reg & ~$past(sel_mask)) ==
		($past(peripheral_mux_enable_reg) & ~$past(sel_mask)) &&
		(drive_strength_reg & ~$past(sel_mask)) ==
		($past(drive_strength_reg) & ~$past(sel_mask)))
		else $error("multi write touched an unmasked pin");
	a_multi_reads_zero: assert property (reg_rd && hit_multi |=> // [R6]
		reg_rdata == 32'h0)
		else $error("multi-pin register read nonzero");
	a_even_func_write: assert property ( // [R9]
		reg_wr && hit_pair && !mc_func_wr |=>
		pin_function_reg[{$past(pair_idx), 1'b0}] ==
		$past(reg_wdata[EVEN_FUNC_LSB +: FUNC_W]) &&
		pin_function_reg[{$past(pair_idx), 1'b1}] ==
		$past(reg_wdata[ODD_FUNC_LSB +: FUNC_W])) // [R8]
		else $error("pair select byte not split onto its pins");
	a_pin_readback: assert property ( // [R17]
		s_pin_byte_write ##1 s_pin_byte_read |=>
		reg_rdata == (32'($past(reg_wdata, 2)) & 32'h47))
		else $error("pin config byte read back wrongly");

	// a byte write stores the four implemented bits of that pin
	a_byte_cfg_store: assert property ( // [R12] [R13]
		reg_wr && hit_pin |=>
		drive_strength_reg[$past(pin_idx)] ==
		$past(reg_wdata[CFG_DRIVE_BIT]) &&
		pull_enable_reg[$past(pin_idx)] ==
		$past(reg_wdata[CFG_PULL_BIT]) &&
		input_buffer_enable_reg[$past(pin_idx)] ==
		$past(reg_wdata[CFG_INBUF_BIT]) && // [R14]
		peripheral_mux_enable_reg[$past(pin_idx)] ==
		$past(reg_wdata[CFG_MUXEN_BIT])) // [R15]
		else $error("pin config byte write not stored");

	// reserved positions of the pin byte always read as zero
	a_pin_reserved_zero: assert property ( // [R17]
		reg_rd && hit_pin |=> (reg_rdata & ~32'h47) == 32'h0)
		else $error("reserved pin config bits read nonzero");

	// pair bytes are eight bits wide; nothing shows above them
	a_pair_high_zero: assert property ( // [R7]
		reg_rd && hit_pair |=> reg_rdata[31:8] == 24'h0)
		else $error("pair select read nonzero above the byte");

	// offsets outside both byte banks, the multi word too, read zero
	a_unmapped_reads_zero: assert property ( // [R6]
		reg_rd && !hit_pin && !hit_pair |=> reg_rdata == 32'h0)
		else $error("unmapped offset read nonzero");

endmodule

/* File: tb/pad_env_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// pads and peripheral functions
// ----------------------------------------
module pad_env_model
	import port_mux_pkg::*;
(
	// clock
	input wire logic mclk,
	// pad side of the block
	input wire logic [PIN_COUNT-1:0] pad_out,
	input wire logic [PIN_COUNT-1:0] pad_oe,
	input wire logic [PIN_COUNT-1:0] pad_pull_en,
	// outside drivers set by the bench
	input wire logic [PIN_COUNT-1:0] ext_en,
	input wire logic [PIN_COUNT-1:0] ext_level,
	// pad levels and peripheral signals
	output logic [PIN_COUNT-1:0] pad_in,
	output logic [PIN_COUNT*FUNC_COUNT-1:0] func_oe,
	output logic [PIN_COUNT*FUNC_COUNT-1:0] func_out
);
	// a floating pad wanders, so a stale level never passes
	logic wander = 1'h0;
	always @(posedge mclk)
		wander <= ~wander;
	// wire level: block driver, outside driver, then pull-up
	always_comb
	begin
		for (int i = 0; i < PIN_COUNT; i++)
		begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_level[i];
			else if (pad_pull_en[i])
				pad_in[i] = 1'h1;
			else
				pad_in[i] = wander;
		end
	end
	// every function drives except D; value is pin lsb xor code lsb
	always_comb
	begin
		for (int i = 0; i < PIN_COUNT*FUNC_COUNT; i++)
		begin
			func_oe[i] = (i % FUNC_COUNT) != 3;
			func_out[i] = i[0] ^ i[3];
		end
	end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
// one compare, counted, reported at once
`define CHK(nm, ex, got) \
	begin \
		n_tests++; \
		if ((got) !== (ex)) \
		begin \
			err_count++; \
			$display("MISMATCH %s exp %h got %h", nm, ex, got); \
		end \
	end
module tb
	import port_mux_pkg::*;
;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic [PIN_COUNT-1:0] port_dir = '0;
	logic [PIN_COUNT-1:0] port_out = '0;
	logic [PIN_COUNT-1:0] ext_en = '0;
	logic [PIN_COUNT-1:0] ext_level = '0;
	logic [PIN_COUNT-1:0] pad_in, pad_out, pad_oe, pin_level;
	logic [PIN_COUNT-1:0] pad_drive_strong, pad_pull_en, pad_in_en;
	logic [PIN_COUNT*FUNC_COUNT-1:0] func_oe, func_out;
	int err_count = 0;
	int n_tests = 0;

	// 100 MHz clock
	always #5 mclk = ~mclk;

	port_pin_config_and_mux port_pin_config_and_mux_inst (.mclk(mclk),
		.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_dir(port_dir), .port_out(port_out), .func_oe(func_oe),
		.func_out(func_out), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_drive_strong(pad_drive_strong),
		.pad_pull_en(pad_pull_en), .pad_in_en(pad_in_en),
		.pin_level(pin_level));

	pad_env_model pad_env_model_inst (.mclk(mclk), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_pull_en(pad_pull_en), .ext_en(ext_en),
		.ext_level(ext_level), .pad_in(pad_in), .func_oe(func_oe),
		.func_out(func_out));

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	// one-cycle write; a gap cycle follows before the next strobe
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask
	// write then read with no gap; the read sees the fresh value
	task wr_rd(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [7:0] ex);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		`CHK("reg_rdata", {24'h0, ex}, reg_rdata)
	endtask
	// read data is only valid in the cycle after the strobe
	task rd(input logic [ADDR_W-1:0] a, input logic [7:0] ex);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		`CHK("reg_rdata", {24'h0, ex}, reg_rdata)
	endtask
	// let registered pad outputs land
	task settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// expected {oe, out}: reserved codes release the pad
	function logic [1:0] drv(input int f, input int p);
		if (f > 7)
			return 2'h0;
		return {1'(f != 3), 1'(f[0] ^ p[0])};
	endfunction
	task end_sim;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard
	initial
	begin
		repeat (100000) @(posedge mclk);
		err_count++;
		end_sim;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		// reset values of every pin config byte
		for (int n = 0; n < PIN_COUNT; n++)
			rd(ADDR_W'(PIN_CFG_OFS + n), 8'h0);
		for (int n = 0; n < PAIR_COUNT; n++)
			wr(ADDR_W'(FUNC_SEL_OFS + n), 32'(n));
		// distinct contents prove each pair byte has its own address
		for (int n = 0; n < PAIR_COUNT; n++)
			rd(ADDR_W'(FUNC_SEL_OFS + n), 8'(n));
		// reserved bits dropped, pin 5 fully on
		wr_rd(7'h45, 32'hff, 8'h47);
		`CHK("drive5", 1'h1, pad_drive_strong[5])
		`CHK("pull5", 1'h1, pad_pull_en[5])
		`CHK("inbuf5", 1'h1, pad_in_en[5])
		// a hole in the map keeps nothing
		wr(7'h20, 32'hff);
		rd(7'h20, 8'h0);
		// sweep every code on pins 4 and 5 with port regs opposed
		wr(7'h44, 32'h03);
		@(posedge mclk);
		port_dir <= '1;
		for (int f = 0; f < 16; f++)
		begin
			wr(7'h32, {24'h0, 4'(f ^ 1), 4'(f)});
			settle(1);
			`CHK("pin4", drv(f, 4), {pad_oe[4], pad_out[4]})
			`CHK("pin5", drv(f ^ 1, 5), {pad_oe[5], pad_out[5]})
		end
		// mux off hands pin 5 back to the port registers
		@(posedge mclk);
		port_out <= 32'h20;
		wr(7'h45, 32'h02);
		settle(1);
		`CHK("port5", 2'h3, {pad_oe[5], pad_out[5]})
		`CHK("mux4", 2'h0, {pad_oe[4], pad_out[4]})
		// multi-pin write, upper half, pins 16 and 17
		wr(MULTI_CFG_OFS, 32'hc0440003);
		rd(7'h50, 8'h44);
		rd(7'h51, 8'h44);
		rd(7'h52, 8'h00);
		rd(MULTI_CFG_OFS, 8'h0);
		// lower half, pin 1 only
		wr(MULTI_CFG_OFS, 32'h40070002);
		rd(7'h41, 8'h07);
		rd(7'h45, 8'h02);
		// without the update flag nothing changes
		wr(MULTI_CFG_OFS, 32'h004f0004);
		rd(7'h42, 8'h00);
		wr(MULTI_CFG_OFS, 32'hc0010001);
		rd(7'h50, 8'h01);
		// function update through the multi word, pins 2 and 3 only
		wr(MULTI_CFG_OFS, 32'h1500000c);
		rd(7'h31, 8'h55);
		rd(7'h30, 8'h00);
		// input path: pin 1 muxed loops back, 16 blind, 5 port input
		@(posedge mclk);
		port_dir <= '0;
		ext_en <= 32'h10020;
		ext_level <= 32'h10020;
		settle(4);
		`CHK("lvl1", 1'h1, pin_level[1])
		`CHK("pull1", 1'h1, pad_pull_en[1])
		`CHK("lvl16", 1'h0, pin_level[16])
		`CHK("lvl5", 1'h1, pin_level[5])
		@(posedge mclk);
		ext_level <= '0;
		settle(4);
		`CHK("lvl5", 1'h0, pin_level[5])
		end_sim;
	end
endmodule
